// ### dv/ccpu_assertions.sv
`timescale 1ns/1ps
// Watches the unit's ports only
module ccpu_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic unit_pin_in,
   input wire logic [15:0] first_timebase_timer,
   input wire logic [15:0] third_timebase_timer,
   input wire logic [7:0] pwm_period_timer,
   input wire logic [7:0] pwm_period_register,
   input wire logic [1:0] pwm_sub_count,
   input wire logic pwm_timer_tick,
   input wire logic unit_pin_out,
   input wire logic unit_irq_flag,
   input wire logic timer_clear,
   input wire logic adc_start,
   input wire logic pwm_period_timer_clear
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // Bus answer timing
   AST_RDY_AFTER: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("pready late");
   AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready held");
   AST_RDY_CAUSE: assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready unasked");
   AST_ERR_RDY: assert property (pslverr |-> pready) else $error("pslverr alone");
   // Flag and event outputs
   AST_FLAG_STICKY: assert property ($fell(unit_irq_flag) |-> $past(psel && pwrite))
      else $error("flag dropped by itself");
   AST_TCLR_PULSE: assert property (timer_clear |=> !timer_clear) else $error("timer clear held");
   AST_ADC_EVENT: assert property (adc_start |-> timer_clear && unit_irq_flag)
      else $error("conversion start without event");
   AST_PCLR_CAUSE: assert property (pwm_period_timer_clear |->
      $past(pwm_timer_tick && pwm_period_timer == pwm_period_register)) else $error("period clear uncaused");
   AST_RESET: assert property (disable iff (1'b0) reset |=> !unit_pin_out && !unit_irq_flag && !pready)
      else $error("outputs not cleared by reset");
   cover property ($rose(unit_irq_flag));
   cover property (adc_start);
   cover property (pwm_period_timer_clear);
endmodule : ccpu_checker
bind ccpu_unit ccpu_checker chk_u (.*);

// ### dv/ccpu_pin_src.sv
`timescale 1ns/1ps
// Far side of the unit pin: an outside source, or the port output when the pin is driven
module ccpu_pin_src (
   input wire logic clk_sys,
   input wire logic drive_en,
   input wire logic port_lvl,
   input wire logic ext_lvl,
   output logic pin_lvl
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin level changes just after an edge, as a real synchronous source would
   always_ff @(posedge clk_sys) begin
      pin_lvl <= drive_en ? port_lvl : ext_lvl;
   end
endmodule : ccpu_pin_src

// ### dv/test_capture_compare_pwm_unit.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_capture_compare_pwm_unit;
   logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, tick = 0;
   logic drv = 0, port = 0, ext = 0, pin, pout, flag, tclr, adc, pclr, pready, perr, rerr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic [15:0] t1 = 0, t3 = 0;
   logic [7:0] ptmr = 0;
   logic [1:0] sub = 0;
   int failures = 0, n_tests = 0, cyc = 0, n_tc = 0, n_adc = 0, n_pc = 0;
   ccpu_unit dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(perr),
      .unit_pin_in(pin), .first_timebase_timer(t1), .third_timebase_timer(t3), .pwm_period_timer(ptmr),
      .pwm_period_register(8'h10), .pwm_sub_count(sub), .pwm_timer_tick(tick), .unit_pin_out(pout),
      .unit_irq_flag(flag), .timer_clear(tclr), .adc_start(adc), .pwm_period_timer_clear(pclr));
   ccpu_pin_src src_u (.clk_sys(clk_sys), .drive_en(drv), .port_lvl(port), .ext_lvl(ext), .pin_lvl(pin));
   initial forever #2.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   // Pulse counters and hang guard
   always @(posedge clk_sys) begin
      cyc++;
      n_tc += (tclr === 1'b1);
      n_adc += (adc === 1'b1);
      n_pc += (pclr === 1'b1);
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      // Wait for the answer; only the hang guard ends a stuck wait
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask : rd
   // Move the outside pin level and let the synchroniser settle
   task edge_to(input logic v);
      ext <= v;
      repeat (6) @(posedge clk_sys);
   endtask : edge_to
   task summarize();
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [3:0] cm [4];
      logic ce [4];
      cm = '{ccpu_pkg::MODE_CMP_SET, ccpu_pkg::MODE_CMP_CLR, ccpu_pkg::MODE_CMP_TOGGLE, ccpu_pkg::MODE_CMP_IRQ};
      ce = '{1'b1, 1'b0, 1'b1, 1'b0};
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      rd(ccpu_pkg::ADDR_CONTROL, 32'h0);
      rd(12'h020, 32'h0);
      `CHK(rerr, 1'b1)
      // Capture on a port write while the pin is an output
      {drv, t1, t3} <= {1'b1, 16'h1234, 16'hABCD};
      wr(ccpu_pkg::ADDR_CONTROL, 32'h5);
      port <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(ccpu_pkg::ADDR_DATA_LOW, 32'h34);
      rd(ccpu_pkg::ADDR_DATA_HIGH, 32'h12);
      rd(ccpu_pkg::ADDR_STATUS, 32'h1);
      drv <= 1'b0;
      wr(ccpu_pkg::ADDR_SETUP, 32'h1);
      edge_to(1'b1);
      rd(ccpu_pkg::ADDR_DATA_LOW, 32'hCD);
      rd(ccpu_pkg::ADDR_DATA_HIGH, 32'hAB);
      wr(ccpu_pkg::ADDR_CONTROL, 32'h4);
      wr(ccpu_pkg::ADDR_STATUS, 32'h0);
      `CHK(flag, 1'b0)
      t3 <= 16'h5555;
      edge_to(1'b0);
      t3 <= 16'h6666;
      edge_to(1'b1);
      rd(ccpu_pkg::ADDR_DATA_LOW, 32'h55);
      // Prescaled capture: only the last edge of each group captures
      for (int k = 0; k < 2; k++) begin
         edge_to(1'b0);
         wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
         wr(ccpu_pkg::ADDR_CONTROL, 32'h6 + k);
         wr(ccpu_pkg::ADDR_STATUS, 32'h0);
         for (int i = 1; i <= (k ? 16 : 4); i++) begin
            t3 <= 16'(i);
            edge_to(1'b1);
            `CHK(flag, 1'(i == (k ? 16 : 4)))
            edge_to(1'b0);
         end
         rd(ccpu_pkg::ADDR_DATA_LOW, k ? 32'h10 : 32'h4);
      end
      // Compare pin actions
      {t1, ext} <= {16'h0, 1'b1};
      wr(ccpu_pkg::ADDR_SETUP, 32'h2);
      wr(ccpu_pkg::ADDR_DATA_LOW, 32'h20);
      wr(ccpu_pkg::ADDR_DATA_HIGH, 32'h0);
      for (int m = 0; m < 4; m++) begin
         wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
         `CHK(pout, 1'b0)
         wr(ccpu_pkg::ADDR_CONTROL, {28'h0, cm[m]});
         wr(ccpu_pkg::ADDR_STATUS, 32'h0);
         t1 <= 16'h0020;
         repeat (4) @(posedge clk_sys);
         `CHK({pout, flag}, {ce[m], 1'b1})
         t1 <= 16'h0;
      end
      wr(ccpu_pkg::ADDR_CONTROL, {28'h0, ccpu_pkg::MODE_CMP_EVENT});
      wr(ccpu_pkg::ADDR_STATUS, 32'h0);
      `CHK(flag, 1'b0)
      t1 <= 16'h0020;
      repeat (4) @(posedge clk_sys);
      `CHK({n_tc, n_adc, flag, pout}, {32'd1, 32'd1, 1'b1, 1'b0})
      // PWM: duty {04,2'b10}, then {FF,2'b10}, against period 0x10
      wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
      wr(ccpu_pkg::ADDR_DATA_LOW, 32'h4);
      wr(ccpu_pkg::ADDR_CONTROL, 32'h2C);
      for (int p = 0; p < 2; p++) begin
         {ptmr, tick} <= {8'h10, 1'b1};
         @(posedge clk_sys);
         tick <= 1'b0;
         repeat (2) @(posedge clk_sys);
         `CHK({pout, n_pc}, {1'b1, 32'(p + 1)})
         {ptmr, sub} <= {8'h04, 2'b01};
         repeat (3) @(posedge clk_sys);
         `CHK(pout, 1'b1)
         sub <= 2'b10;
         repeat (3) @(posedge clk_sys);
         `CHK(pout, 1'(p))
         rd(ccpu_pkg::ADDR_DATA_HIGH, p ? 32'hFF : 32'h4);
         wr(ccpu_pkg::ADDR_DATA_HIGH, 32'h77);
         rd(ccpu_pkg::ADDR_DATA_HIGH, p ? 32'hFF : 32'h4);
         wr(ccpu_pkg::ADDR_DATA_LOW, 32'hFF);
      end
      // Zero duty: period end must leave the pin low
      wr(ccpu_pkg::ADDR_DATA_LOW, 32'h0);
      wr(ccpu_pkg::ADDR_CONTROL, 32'hC);
      {ptmr, tick} <= {8'h10, 1'b1};
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK({pout, n_pc}, {1'b0, 32'd3})
      summarize();
   end
endmodule : test_capture_compare_pwm_unit

// ### hw/ccpu_unit.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module ccpu_unit (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Pin level, timers and PWM timebase
   input wire logic unit_pin_in,
   input wire logic [15:0] first_timebase_timer,
   input wire logic [15:0] third_timebase_timer,
   input wire logic [7:0] pwm_period_timer,
   input wire logic [7:0] pwm_period_register,
   input wire logic [1:0] pwm_sub_count,
   input wire logic pwm_timer_tick,
   // Outputs
   output logic unit_pin_out,
   output logic unit_irq_flag,
   output logic timer_clear,
   output logic adc_start,
   output logic pwm_period_timer_clear
);
   ////////////////////////////////////////////////////////////////////////////////
   ccpu_pkg::ccpu_state_t s_q;  // Registered state
   ccpu_pkg::ccpu_state_t s_d;  // Next state
   logic [3:0] mode;            // Current mode field
   logic cap_mode;              // Capture mode active
   logic cmp_mode;              // Compare mode active
   logic pwm_mode;              // PWM mode active
   logic rise;                  // Synchronised rising edge
   logic fall;                  // Synchronised falling edge
   logic capture;               // Qualifying capture event
   logic [15:0] tsel;           // Selected timebase value
   logic match;                 // Compare equality
   logic wr;                    // APB write access phase
   logic rd;                    // APB read access phase
   logic [9:0] pwm_cnt;         // Extended period count
   logic period_end;            // Period timer at period and ticking

   assign mode = s_q.control[ccpu_pkg::MODE_MSB:ccpu_pkg::MODE_LSB];
   assign pwm_mode = (mode[3:2] == ccpu_pkg::MODE_PWM_TOP);
   assign cap_mode = (mode[3:2] == ccpu_pkg::MODE_CAP_TOP);
   assign cmp_mode = (mode == ccpu_pkg::MODE_CMP_TOGGLE) || (mode[3:2] == ccpu_pkg::MODE_CMP_TOP);
   assign rise = s_q.pin_s2 && !s_q.pin_s3;
   assign fall = !s_q.pin_s2 && s_q.pin_s3;
   assign tsel = s_q.timer_sel ? third_timebase_timer : first_timebase_timer;
   assign match = cmp_mode && (tsel == {s_q.data_high, s_q.data_low});
   assign wr = psel && penable && pwrite && !s_q.pready;
   assign rd = psel && penable && !pwrite && !s_q.pready;
   assign pwm_cnt = {pwm_period_timer, pwm_sub_count};
   // Postscaler not involved: only the raw tick and count are used
   assign period_end = pwm_timer_tick && (pwm_period_timer == pwm_period_register);

   ////////////////////////////////////////////////////////////////////////////////
   // Capture event qualification per mode
   always_comb begin
      capture = 1'b0;
      unique case (mode)
         ccpu_pkg::MODE_CAP_FALL: capture = fall;
         ccpu_pkg::MODE_CAP_RISE: capture = rise;
         ccpu_pkg::MODE_CAP_RISE4: capture = rise && (s_q.presc[1:0] == ccpu_pkg::PRESC_4_LAST[1:0]);
         ccpu_pkg::MODE_CAP_RISE16: capture = rise && (s_q.presc == ccpu_pkg::PRESC_16_LAST);
         default: capture = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.tmr_clear = 1'b0;
      s_d.adc_start = 1'b0;
      s_d.pwm_period_clear = 1'b0;
      // Synchroniser chain
      s_d.pin_s1 = unit_pin_in;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.match_q = match;
      // Prescaler counts rising edges; held clear outside capture
      if (!cap_mode) begin
         s_d.presc = '0;
      end else if (rise) begin
         s_d.presc = s_q.presc + 4'h1;
      end
      // Capture overwrites data regardless of whether it was read
      if (cap_mode && capture) begin
         {s_d.data_high, s_d.data_low} = tsel;
      end
      // Compare match acts on rising of equality only
      if (match && !s_q.match_q) begin
         unique case (mode)
            ccpu_pkg::MODE_CMP_TOGGLE: s_d.out_latch = !s_q.out_latch;
            ccpu_pkg::MODE_CMP_SET: s_d.out_latch = 1'b1;
            ccpu_pkg::MODE_CMP_CLR: s_d.out_latch = 1'b0;
            ccpu_pkg::MODE_CMP_IRQ: s_d.out_latch = s_q.out_latch;
            ccpu_pkg::MODE_CMP_EVENT: begin
               // Timer reset pulse, and conversion start if adc_en; no timer flag is raised here
               s_d.tmr_clear = 1'b1;
               s_d.adc_start = s_q.adc_en;
            end
            default: s_d.out_latch = s_q.out_latch;
         endcase
      end
      // PWM: period end reloads duty and sets pin unless duty is zero, duty match clears pin
      if (pwm_mode) begin
         if (period_end) begin
            s_d.pwm_period_clear = 1'b1;
            s_d.data_high = s_q.data_low;
            s_d.duty_latch = s_q.control[ccpu_pkg::DUTY_MSB:ccpu_pkg::DUTY_LSB];
            s_d.out_latch = ({s_q.data_low, s_q.control[ccpu_pkg::DUTY_MSB:ccpu_pkg::DUTY_LSB]} != 10'h000);
         end else if ({s_q.data_high, s_q.duty_latch} == pwm_cnt) begin
            // Duty beyond the period never reaches equality
            s_d.out_latch = 1'b0;
         end
      end
      // APB write
      if (wr) begin
         s_d.pready = 1'b1;
         unique case (paddr)
            ccpu_pkg::ADDR_CONTROL: begin
               s_d.control = pwdata[7:0] & ccpu_pkg::CONTROL_MASK;
               if ((pwdata[3:0] == ccpu_pkg::MODE_OFF)) begin
                  s_d.out_latch = 1'b0;
                  s_d.presc = '0;
                  s_d.duty_latch = '0;
               end else if (pwdata[3:0] == ccpu_pkg::MODE_CMP_SET) begin
                  s_d.out_latch = 1'b0;
               end else if (pwdata[3:0] == ccpu_pkg::MODE_CMP_CLR) begin
                  s_d.out_latch = 1'b1;
               end
            end
            ccpu_pkg::ADDR_DATA_LOW: begin
               if (!(cap_mode && capture)) begin
                  s_d.data_low = pwdata[7:0];
               end
            end
            ccpu_pkg::ADDR_DATA_HIGH: begin
               if (!pwm_mode && !(cap_mode && capture)) begin
                  s_d.data_high = pwdata[7:0];
               end
            end
            ccpu_pkg::ADDR_STATUS: begin
               s_d.flag = pwdata[ccpu_pkg::STATUS_FLAG];
            end
            ccpu_pkg::ADDR_SETUP: begin
               s_d.timer_sel = pwdata[ccpu_pkg::SETUP_TIMER_SEL];
               s_d.adc_en = pwdata[ccpu_pkg::SETUP_ADC_EN];
            end
            default: s_d.pslverr = ccpu_pkg::APB_ERR;
         endcase
      end
      // APB read
      if (rd) begin
         s_d.pready = 1'b1;
         s_d.prdata = '0;
         unique case (paddr)
            ccpu_pkg::ADDR_CONTROL: s_d.prdata[7:0] = s_q.control;
            ccpu_pkg::ADDR_DATA_LOW: s_d.prdata[7:0] = s_q.data_low;
            ccpu_pkg::ADDR_DATA_HIGH: s_d.prdata[7:0] = s_q.data_high;
            ccpu_pkg::ADDR_STATUS: begin
               s_d.prdata[ccpu_pkg::STATUS_FLAG] = s_q.flag;
               s_d.prdata[ccpu_pkg::STATUS_PIN] = s_q.out_latch;
            end
            ccpu_pkg::ADDR_SETUP: begin
               s_d.prdata[ccpu_pkg::SETUP_TIMER_SEL] = s_q.timer_sel;
               s_d.prdata[ccpu_pkg::SETUP_ADC_EN] = s_q.adc_en;
            end
            default: s_d.pslverr = ccpu_pkg::APB_ERR;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle
      if ((cap_mode && capture) || (match && !s_q.match_q)) begin
         s_d.flag = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset and clock enable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= '0;
         s_q.control <= ccpu_pkg::CONTROL_RESET;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign pready = s_q.pready;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;
   assign unit_pin_out = s_q.out_latch;
   assign unit_irq_flag = s_q.flag;
   assign timer_clear = s_q.tmr_clear;
   assign adc_start = s_q.adc_start;
   assign pwm_period_timer_clear = s_q.pwm_period_clear;
endmodule : ccpu_unit

// ### inc/ccpu_pkg.sv
// Operation
// - Capture copies selected 16-bit timer
// - Four capture event kinds by mode
// - Capture codes 0100 to 0111
// - Every capture sets sticky irq flag
// - New capture overwrites old value
// - Edges seen on pin level always
// - Prescaler cleared outside capture modes
// - Prescaler switch keeps counter, may flag
// - Compare data against timer every cycle
// - Match drives high, low, toggles, none
// - Compare codes and reserved codes
// - Control write zero clears output latch
// - Software interrupt mode leaves pin
// - Special event clears selected timer
// - Second unit event starts conversion
// - Event timer reset sets no timer flag
// - Period end clears timer, sets pin if duty nonzero, loads
// - Postscaler unused for PWM
// - Duty is low byte and control bits
// - High byte read-only active duty in PWM
// - Pin clears when duty meets count
// - Duty above period never clears pin
// - 11xx PWM, 0000 disables and resets
package ccpu_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_DATA_LOW = 12'h004;
   localparam logic [11:0] ADDR_DATA_HIGH = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_SETUP = 12'h010;
   // Control fields
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int DUTY_LSB = 4;
   localparam int DUTY_MSB = 5;
   localparam logic [7:0] CONTROL_MASK = 8'h3F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // Status and setup bit positions
   localparam int STATUS_FLAG = 0;
   localparam int STATUS_PIN = 1;
   localparam int SETUP_TIMER_SEL = 0;
   localparam int SETUP_ADC_EN = 1;
   // Mode codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_IRQ = 4'hA;
   localparam logic [3:0] MODE_CMP_EVENT = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP = 2'h3;
   localparam logic [1:0] MODE_CAP_TOP = 2'h1;   // Upper mode bits of the capture codes
   localparam logic [1:0] MODE_CMP_TOP = 2'h2;   // Upper mode bits of compare codes 8 to B, not toggle
   // Prescaler terminal counts
   localparam logic [3:0] PRESC_4_LAST = 4'h3;
   localparam logic [3:0] PRESC_16_LAST = 4'hF;
   // APB slave error answer for unmapped addresses
   localparam logic APB_ERR = 1'b1;
   // Whole state of the unit
   typedef struct packed {
      logic [7:0] control;       // Mode and duty low bits
      logic [7:0] data_low;      // Data low byte / next duty
      logic [7:0] data_high;     // Data high byte / active duty
      logic [1:0] duty_latch;    // Hidden active duty low bits
      logic flag;                // Unit irq flag
      logic timer_sel;           // 0 first timer, 1 third timer
      logic adc_en;              // Converter enabled
      logic [3:0] presc;         // Capture edge prescaler
      logic pin_s1;              // Synchroniser stage one
      logic pin_s2;              // Synchroniser stage two
      logic pin_s3;              // Previous synchronised level
      logic out_latch;           // Compare/PWM output latch
      logic match_q;             // Previous compare match
      logic tmr_clear;           // Timer clear strobe
      logic adc_start;           // Conversion start strobe
      logic pwm_period_clear;    // Period timer clear strobe
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ccpu_state_t;
endpackage : ccpu_pkg
